// ---- hw/bcc_top.sv ----
// Notes on behaviour
// R1 - Vector read low forces address bit 0 low.
// R2 - Memory write out: DMA strobe in DMA mode, else CPU write.
// R3 - I/O command pins: inputs in DMA mode, else driven from CPU.
// R4 - Processor reset is high while power switches on or off.
// R5 - System reset is asserted at power on.
// R6 - Upper RAM enable input must be held at zero by the system.
// R7 - Colour video select asserted for 0B8000H to 0BBFFFH.
// R8 - Refresh enable high runs the refresh circuit.
// R9 - Phase low drives refresh address bit 0 and active.
// R10 - Dummy address drives second byte; read first byte latched on its rise.
// R11 - Swap direction low copies high to low bank, high the reverse.
// R12 - Swap enable low only while the second byte transfers.
// R13 - Latch strobe pulses high to capture the dummy address.
// R14 - Processor hold request follows the DMA hold request.
// R15 - Base RAM access low for 0 to 640K, also enabling parity checks.
// R16 - BIOS ROM select low for 0E0000H-0FFFFFH and FE0000H-FFFFFFH.
// R17 - Inverted address bit 0 in CPU cycles; high makes low byte enable.
// R18 - Outside logic drives the system memory indicator.
// R19 - Zero wait request ends the CPU cycle without wait states.
// R20 - Master DMA holds address enable for the whole operation.
// R21 - Address bits 16 and 15 select the video memory chips.
// R22 - Hold acknowledge to DMA only after the CPU grants the hold.
// R23 - DMA ready held low for one wait cycle, then high.
// R24 - Outputs clocked except the three enables; all but the two resets cleared by power on reset.
`timescale 1ns/10ps
`default_nettype none
module bcc_top (
	// Clock, enable, reset
	input  wire logic        MCLK,
	input  wire logic        SRST,
	input  wire logic        CE,
	// Power and reset
	input  wire logic        POWER_ON_RESET_N,
	input  wire logic        POWER_OFF_REQ,
	output logic             PROCESSOR_RESET_OUT,
	output logic             SYSTEM_RESET_OUT,
	// CPU bus
	input  wire logic [23:0] CPU_ADDR,
	input  wire logic [7:0]  CPU_DATA_LO,
	input  wire logic        CPU_MEM_CYCLE,
	input  wire logic        CPU_READ,
	input  wire logic        CPU_BHE_N,
	input  wire logic        CPU_MEMW_N,
	input  wire logic        CPU_IOR_N,
	input  wire logic        CPU_IOW_N,
	input  wire logic        INT_ACK_N,
	input  wire logic        TARGET_8BIT,
	input  wire logic        ZERO_WAIT_REQUEST,
	output logic             CPU_READY_N,
	output logic             SYS_ADDR_BIT0,
	output logic             SYS_ADDR_BIT0_OE,
	output logic             INVERTED_ADDR_BIT0,
	output logic             LOW_BYTE_ENABLE_N,
	output logic [7:0]       FIRST_BYTE,
	// DMA side
	input  wire logic        DMA_HOLD_REQUEST_IN,
	input  wire logic        PROCESSOR_HOLD_ACK_IN,
	input  wire logic        MASTER_DMA_ADDR_ENABLE_N,
	input  wire logic        DMAC_MEMW_N,
	output logic             PROCESSOR_HOLD_REQUEST,
	output logic             DMA_HOLD_ACK_OUT,
	output logic             DMA_READY_OUT,
	output logic             DMA_MEM_WRITE_CMD,
	input  wire logic        DMA_IO_READ_CMD_I,
	output logic             DMA_IO_READ_CMD_O,
	output logic             DMA_IO_READ_CMD_OE,
	input  wire logic        DMA_IO_WRITE_CMD_I,
	output logic             DMA_IO_WRITE_CMD_O,
	output logic             DMA_IO_WRITE_CMD_OE,
	// Memory decode
	input  wire logic        UPPER_RAM_ACCESS_ENABLE,
	input  wire logic        SYSTEM_MEMORY_INDICATOR,
	output logic             COLOR_VIDEO_MEM_SELECT,
	output logic [1:0]       VIDEO_CHIP_SEL,
	output logic             BIOS_ROM_SEL_N,
	output logic             BASE_RAM_ACCESS_N,
	// Refresh
	input  wire logic        REFRESH_ENABLE_IN,
	output logic             REFRESH_ACTIVE_OUT,
	output logic             REFRESH_COUNTER_PHASE,
	output logic             REFRESH_ADDR_BIT0,
	// 16/8 conversion
	output logic             SECOND_BYTE_DUMMY_ADDR,
	output logic             BYTE_SWAP_DIRECTION,
	output logic             BYTE_SWAP_ENABLE_N,
	output logic             DUMMY_ADDR_LATCH_STROBE
);
	// ---------------------------------------------------------------
	// Input synchronisers
	// ---------------------------------------------------------------
	logic [bcc_pkg::SYNC_W-1:0] raw;
	logic [bcc_pkg::SYNC_W-1:0] syn;
	logic [23:0]                a;
	logic [7:0]                 d;
	logic por_n, pwr_off, hrq, hlda_in, aen_n, dmemw_n, dior_n, diow_n;
	logic ref_en, cyc, rd, bhe_n, memw_n, ior_n, iow_n, inta_n, t8, zw;
	logic ram_op, sys_ind;
	logic rst;

	assign raw = {CPU_ADDR, CPU_DATA_LO, POWER_ON_RESET_N, POWER_OFF_REQ,
		DMA_HOLD_REQUEST_IN, PROCESSOR_HOLD_ACK_IN, MASTER_DMA_ADDR_ENABLE_N,
		DMAC_MEMW_N, DMA_IO_READ_CMD_I, DMA_IO_WRITE_CMD_I, REFRESH_ENABLE_IN,
		CPU_MEM_CYCLE, CPU_READ, CPU_BHE_N, CPU_MEMW_N, CPU_IOR_N, CPU_IOW_N,
		INT_ACK_N, TARGET_8BIT, ZERO_WAIT_REQUEST, UPPER_RAM_ACCESS_ENABLE,
		SYSTEM_MEMORY_INDICATOR};

	bcc_sync2 #(
		.W   (bcc_pkg::SYNC_W),
		.RST (bcc_pkg::SYNC_RST)
	) u_sync (
		.clk  (MCLK),
		.srst (SRST),
		.ce   (CE),
		.d    (raw),
		.q    (syn)
	);

	assign {a, d, por_n, pwr_off, hrq, hlda_in, aen_n, dmemw_n, dior_n,
		diow_n, ref_en, cyc, rd, bhe_n, memw_n, ior_n, iow_n, inta_n, t8, zw,
		ram_op, sys_ind} = syn;

	// Power on reset clears the block too
	assign rst = SRST | ~por_n; // R24

	// ---------------------------------------------------------------
	// Reset outputs
	// ---------------------------------------------------------------
	// Held active through SRST; sync stage starts at zero so resets assert
	always_ff @(posedge MCLK) begin
		if (SRST) begin
			PROCESSOR_RESET_OUT <= 1'b1;
			SYSTEM_RESET_OUT    <= 1'b1;
		end else if (CE) begin
			PROCESSOR_RESET_OUT <= ~por_n | pwr_off; // R4
			SYSTEM_RESET_OUT    <= ~por_n; // R5
		end
	end

	// ---------------------------------------------------------------
	// Hold handshake
	// ---------------------------------------------------------------
	logic dma_mode;

	// Ack only once the CPU has granted; drops with the request
	always_ff @(posedge MCLK) begin
		if (rst) begin
			PROCESSOR_HOLD_REQUEST <= 1'b0;
			DMA_HOLD_ACK_OUT       <= 1'b0;
		end else if (CE) begin
			PROCESSOR_HOLD_REQUEST <= hrq; // R14
			DMA_HOLD_ACK_OUT       <= hrq & hlda_in; // R22
		end
	end

	assign dma_mode = DMA_HOLD_ACK_OUT;

	// ---------------------------------------------------------------
	// Command routing
	// ---------------------------------------------------------------
	// Pins released while the DMA owns the I/O commands
	assign DMA_IO_READ_CMD_OE  = ~dma_mode; // R3
	assign DMA_IO_WRITE_CMD_OE = ~dma_mode; // R3

	// Commands, all active low
	always_ff @(posedge MCLK) begin
		if (rst) begin
			DMA_MEM_WRITE_CMD  <= 1'b1;
			DMA_IO_READ_CMD_O  <= 1'b1;
			DMA_IO_WRITE_CMD_O <= 1'b1;
		end else if (CE) begin
			DMA_MEM_WRITE_CMD  <= dma_mode ? dmemw_n : memw_n; // R2
			DMA_IO_READ_CMD_O  <= ior_n; // R3
			DMA_IO_WRITE_CMD_O <= iow_n; // R3
		end
	end

	// ---------------------------------------------------------------
	// DMA wait state
	// ---------------------------------------------------------------
	logic dcmd;
	logic dcmd_d;

	// Master DMA holds its address enable for the whole operation
	assign dcmd = dma_mode & ~aen_n & (~dmemw_n | ~dior_n | ~diow_n); // R20

	// One low cycle at the start of every DMA command
	always_ff @(posedge MCLK) begin
		if (rst) begin
			dcmd_d        <= 1'b0;
			DMA_READY_OUT <= 1'b1;
		end else if (CE) begin
			dcmd_d        <= dcmd;
			DMA_READY_OUT <= ~(dcmd & ~dcmd_d); // R23
		end
	end

	// ---------------------------------------------------------------
	// Address decode
	// ---------------------------------------------------------------
	logic mem_act;
	logic in_cga;
	logic in_rom;
	logic in_base;

	assign mem_act = cyc | dma_mode;
	assign in_cga  = (a >= bcc_pkg::CGA_LO) && (a <= bcc_pkg::CGA_HI);
	assign in_rom  = ((a >= bcc_pkg::ROM1_LO) && (a <= bcc_pkg::ROM1_HI))
		|| ((a >= bcc_pkg::ROM2_LO) && (a <= bcc_pkg::ROM2_HI));
	// Upper 128K only when the enable input is at zero
	assign in_base = (a <= bcc_pkg::BASE_HI)
		&& ((a < bcc_pkg::UPPER_LO) || ~ram_op); // R6

	// Registered to hide address skew
	always_ff @(posedge MCLK) begin
		if (rst) begin
			COLOR_VIDEO_MEM_SELECT <= 1'b0;
			VIDEO_CHIP_SEL         <= 2'h0;
			BIOS_ROM_SEL_N         <= 1'b1;
			BASE_RAM_ACCESS_N      <= 1'b1;
		end else if (CE) begin
			COLOR_VIDEO_MEM_SELECT <= mem_act & in_cga; // R7
			VIDEO_CHIP_SEL         <= a[bcc_pkg::VSEL_MSB:bcc_pkg::VSEL_LSB]; // R21
			BIOS_ROM_SEL_N         <= ~(mem_act & in_rom); // R16
			BASE_RAM_ACCESS_N      <= ~(mem_act & in_base & sys_ind); // R15 R18
		end
	end

	// ---------------------------------------------------------------
	// Address bit 0 handling
	// ---------------------------------------------------------------
	assign SYS_ADDR_BIT0_OE = ~dma_mode;

	// Vector reads must see an even address
	always_ff @(posedge MCLK) begin
		if (rst) begin
			SYS_ADDR_BIT0      <= 1'b0;
			INVERTED_ADDR_BIT0 <= 1'b0;
			LOW_BYTE_ENABLE_N  <= 1'b1;
		end else if (CE) begin
			SYS_ADDR_BIT0      <= inta_n & a[0]; // R1
			INVERTED_ADDR_BIT0 <= cyc & ~dma_mode & ~a[0]; // R17
			LOW_BYTE_ENABLE_N  <= ~(cyc & ~dma_mode & ~a[0]); // R17
		end
	end

	// ---------------------------------------------------------------
	// Refresh
	// ---------------------------------------------------------------
	logic [bcc_pkg::REF_CW-1:0] ref_cnt;
	logic                       ref_row;

	// Advances only while enabled
	always_ff @(posedge MCLK) begin
		if (rst) begin
			ref_cnt <= bcc_pkg::REF_CNT_RST;
			ref_row <= 1'b0;
		end else if (CE && ref_en) begin // R8
			ref_cnt <= ref_cnt + 1'b1;
			if (ref_cnt == bcc_pkg::REF_CNT_RST) begin
				ref_row <= ~ref_row;
			end
		end
	end

	// Phase registered with address and strobe so all three align
	always_ff @(posedge MCLK) begin
		if (rst) begin
			REFRESH_COUNTER_PHASE <= bcc_pkg::REF_CNT_RST[bcc_pkg::REF_PH];
			REFRESH_ACTIVE_OUT <= 1'b0;
			REFRESH_ADDR_BIT0  <= 1'b0;
		end else if (CE) begin
			REFRESH_COUNTER_PHASE <= ref_cnt[bcc_pkg::REF_PH]; // R9
			REFRESH_ACTIVE_OUT <= ref_en & ~ref_cnt[bcc_pkg::REF_PH]; // R9
			REFRESH_ADDR_BIT0  <= ~ref_cnt[bcc_pkg::REF_PH] & ref_row; // R9
		end
	end

	// ---------------------------------------------------------------
	// 16/8 conversion sequencer
	// ---------------------------------------------------------------
	bcc_pkg::bcc_conv_e state;
	bcc_pkg::bcc_conv_e next_state;
	logic               start;

	// Word access to a byte-wide target on an even address
	assign start = cyc & t8 & ~bhe_n & ~a[0] & ~dma_mode;

	always_comb begin
		next_state = state;
		case (state)
			bcc_pkg::BCC_IDLE: begin
				if (start) begin
					next_state = bcc_pkg::BCC_FIRST;
				end
			end
			bcc_pkg::BCC_FIRST:  next_state = bcc_pkg::BCC_LATCH;
			bcc_pkg::BCC_LATCH:  next_state = bcc_pkg::BCC_SECOND;
			bcc_pkg::BCC_SECOND: next_state = bcc_pkg::BCC_DONE;
			bcc_pkg::BCC_DONE: begin
				if (!cyc) begin
					next_state = bcc_pkg::BCC_IDLE;
				end
			end
			default: next_state = bcc_pkg::BCC_IDLE;
		endcase
	end

	always_ff @(posedge MCLK) begin
		if (rst) begin
			state <= bcc_pkg::BCC_IDLE;
		end else if (CE) begin
			state <= next_state;
		end
	end

	// Strobe, dummy address and swap enable follow the next state so they align with it
	always_ff @(posedge MCLK) begin
		if (rst) begin
			DUMMY_ADDR_LATCH_STROBE <= 1'b0;
			SECOND_BYTE_DUMMY_ADDR  <= 1'b0;
			BYTE_SWAP_ENABLE_N      <= 1'b1;
			BYTE_SWAP_DIRECTION     <= 1'b0;
		end else if (CE) begin
			DUMMY_ADDR_LATCH_STROBE <= next_state == bcc_pkg::BCC_LATCH; // R13
			SECOND_BYTE_DUMMY_ADDR  <= next_state == bcc_pkg::BCC_SECOND; // R10
			BYTE_SWAP_ENABLE_N      <= next_state != bcc_pkg::BCC_SECOND; // R12
			if (state == bcc_pkg::BCC_IDLE) begin
				BYTE_SWAP_DIRECTION <= rd; // R11
			end
		end
	end

	// First byte captured as the dummy address rises on a read
	always_ff @(posedge MCLK) begin
		if (rst) begin
			FIRST_BYTE <= 8'h00;
		end else if (CE && rd && state == bcc_pkg::BCC_LATCH) begin
			FIRST_BYTE <= d; // R10
		end
	end

	// ---------------------------------------------------------------
	// CPU ready
	// ---------------------------------------------------------------
	logic cyc_d;

	// Plain cycles: one wait state unless zero wait is requested; conversions wait for BCC_DONE
	always_ff @(posedge MCLK) begin
		if (rst) begin
			cyc_d       <= 1'b0;
			CPU_READY_N <= 1'b1;
		end else if (CE) begin
			cyc_d       <= cyc;
			CPU_READY_N <= ~((state == bcc_pkg::BCC_DONE)
				| (cyc & ~start & (state == bcc_pkg::BCC_IDLE) & (zw | cyc_d))); // R19
		end
	end

	// ---------------------------------------------------------------
	// Assertions
	// ---------------------------------------------------------------
	property p_inta;
		@(posedge MCLK) disable iff (rst) CE && !inta_n |=> !SYS_ADDR_BIT0;
	endproperty
	a_inta: assert property (p_inta) else $error("bit0 not forced low"); // R1

	property p_memw;
		@(posedge MCLK) disable iff (rst)
			CE && !dma_mode |=> DMA_MEM_WRITE_CMD == $past(memw_n);
	endproperty
	a_memw: assert property (p_memw) else $error("cpu write not passed"); // R2

	property p_ior;
		@(posedge MCLK) disable iff (rst)
			CE && !ior_n |=> !DMA_IO_READ_CMD_O;
	endproperty
	a_ior: assert property (p_ior) else $error("io read not driven"); // R3

	property p_processor_reset_out;
		@(posedge MCLK) disable iff (SRST) CE && pwr_off |=> PROCESSOR_RESET_OUT;
	endproperty
	a_processor_reset_out: assert property (p_processor_reset_out) else $error("cpu reset missing"); // R4

	property p_cga;
		@(posedge MCLK) disable iff (rst)
			CE && cyc && in_cga |=> COLOR_VIDEO_MEM_SELECT && BIOS_ROM_SEL_N;
	endproperty
	a_cga: assert property (p_cga) else $error("video select wrong"); // R7

	property p_ref;
		@(posedge MCLK) disable iff (rst)
			CE && ref_en |=> REFRESH_ACTIVE_OUT == !REFRESH_COUNTER_PHASE;
	endproperty
	a_ref: assert property (p_ref) else $error("refresh not active"); // R9

	property p_conv;
		@(posedge MCLK) disable iff (rst)
			CE && DUMMY_ADDR_LATCH_STROBE |=>
			!BYTE_SWAP_ENABLE_N && SECOND_BYTE_DUMMY_ADDR && !DUMMY_ADDR_LATCH_STROBE;
	endproperty
	a_conv: assert property (p_conv) else $error("second byte phase wrong"); // R12

	property p_hold;
		@(posedge MCLK) disable iff (rst)
			CE && hrq && hlda_in |=> PROCESSOR_HOLD_REQUEST && DMA_HOLD_ACK_OUT;
	endproperty
	a_hold: assert property (p_hold) else $error("hold handshake wrong"); // R14

	property p_dma_ready_out;
		@(posedge MCLK) disable iff (rst)
			CE && !DMA_READY_OUT |=> DMA_READY_OUT;
	endproperty
	a_dma_ready_out: assert property (p_dma_ready_out) else $error("dma wait too long"); // R23
endmodule // bcc_top
`default_nettype wire

// ---- include/bcc_pkg.sv ----
`default_nettype none
package bcc_pkg;
	// ----------
	// Memory map decode bounds (inclusive)
	// ----------
	localparam logic [23:0] CGA_LO   = 24'h0B8000;
	localparam logic [23:0] CGA_HI   = 24'h0BBFFF;
	localparam logic [23:0] ROM1_LO  = 24'h0E0000;
	localparam logic [23:0] ROM1_HI  = 24'h0FFFFF;
	localparam logic [23:0] ROM2_LO  = 24'hFE0000;
	localparam logic [23:0] ROM2_HI  = 24'hFFFFFF;
	localparam logic [23:0] UPPER_LO = 24'h080000;
	localparam logic [23:0] BASE_HI  = 24'h09FFFF;
	// ----------
	// Field positions and widths
	// ----------
	localparam int AW        = 24;
	localparam int DW        = 8;
	localparam int VSEL_LSB  = 15;
	localparam int VSEL_MSB  = 16;
	localparam int REF_CW    = 4;
	localparam int REF_PH    = 3;
	localparam int CTL_W     = 20;
	localparam int SYNC_W    = 52;
	// ----------
	// Reset values
	// ----------
	localparam logic [REF_CW-1:0] REF_CNT_RST = 4'hF;
	localparam logic [SYNC_W-1:0] SYNC_RST    = 52'h0;
	// ----------
	// 16/8 conversion sequence
	// ----------
	typedef enum logic [2:0] {
		BCC_IDLE   = 3'b000,
		BCC_FIRST  = 3'b001,
		BCC_LATCH  = 3'b010,
		BCC_SECOND = 3'b011,
		BCC_DONE   = 3'b100
	} bcc_conv_e;
endpackage
`default_nettype wire

// ---- hw/bcc_sync2.sv ----
`timescale 1ns/10ps
`default_nettype none
module bcc_sync2 #(
	parameter int                 W   = 1,
	parameter logic [W-1:0]       RST = '0
) (
	// Clock and control
	input  wire logic             clk,
	input  wire logic             srst,
	input  wire logic             ce,
	// Data
	input  wire logic [W-1:0]     d,
	output logic      [W-1:0]     q
);
	logic [W-1:0] meta;

	// Two stages; first stage feeds only the second
	always_ff @(posedge clk) begin
		if (srst) begin
			meta <= RST;
			q    <= RST;
		end else if (ce) begin
			meta <= d;
			q    <= meta;
		end
	end
endmodule // bcc_sync2
`default_nettype wire

// ---- test/bcc_partner.sv ----
`timescale 1ns/10ps
`default_nettype none
module bcc_partner (
	// Clock and scenario control
	input  wire logic       clk,
	input  wire logic       go,
	input  wire logic [1:0] cmd_sel,
	output logic            busy,
	// Hold handshake
	input  wire logic       hold_req,
	input  wire logic       hold_ack,
	input  wire logic       dma_ready,
	output logic            hold_grant,
	output logic            dma_hrq,
	// DMA command lines, active low; cmd_oe active high
	output logic            aen_n,
	output logic            memw_n,
	output logic            ior_n,
	output logic            iow_n,
	output logic            cmd_oe
);
	logic [3:0] grant_cnt;
	int         n;

	// Late grant exposes an early acknowledge
	always_ff @(posedge clk) begin
		if (hold_req !== 1'b1) begin
			grant_cnt  <= 4'h0;
			hold_grant <= 1'b0;
		end else if (grant_cnt == 4'h5) begin
			hold_grant <= 1'b1;
		end else begin
			grant_cnt <= grant_cnt + 4'h1;
		end
	end

	// Controller: one transfer per go pulse
	initial begin
		busy    = 1'b0;
		dma_hrq = 1'b0;
		aen_n   = 1'b1;
		memw_n  = 1'b1;
		ior_n   = 1'b1;
		iow_n   = 1'b1;
		cmd_oe  = 1'b0;
		forever begin
			@(posedge clk);
			if (go === 1'b1) begin
				busy    <= 1'b1;
				dma_hrq <= 1'b1;
				n = 0;
				// Wait for the acknowledge
				while (hold_ack !== 1'b1 && n < 40) begin
					@(posedge clk);
					n++;
				end
				aen_n  <= 1'b0;
				cmd_oe <= 1'b1;
				@(posedge clk);
				memw_n <= (cmd_sel != 2'd2);
				ior_n  <= (cmd_sel != 2'd0);
				iow_n  <= (cmd_sel != 2'd1);
				n = 0;
				// Hold through the wait cycle
				while (dma_ready !== 1'b0 && n < 20) begin
					@(posedge clk);
					n++;
				end
				while (dma_ready !== 1'b1 && n < 20) begin
					@(posedge clk);
					n++;
				end
				memw_n <= 1'b1;
				ior_n  <= 1'b1;
				iow_n  <= 1'b1;
				@(posedge clk);
				aen_n   <= 1'b1;
				cmd_oe  <= 1'b0;
				dma_hrq <= 1'b0;
				busy    <= 1'b0;
			end
		end
	end
endmodule // bcc_partner
`default_nettype wire

// ---- test/testbench.sv ----
`timescale 1ns/10ps
`default_nettype none
module testbench;
	// ----------
	// Signals
	// ----------
	logic        MCLK, SRST, CE, POWER_ON_RESET_N, POWER_OFF_REQ, PROCESSOR_RESET_OUT, SYSTEM_RESET_OUT;
	logic [23:0] CPU_ADDR;
	logic [7:0]  CPU_DATA_LO, FIRST_BYTE;
	logic        CPU_MEM_CYCLE, CPU_READ, CPU_BHE_N, CPU_MEMW_N, CPU_IOR_N, CPU_IOW_N, INT_ACK_N, TARGET_8BIT;
	logic        ZERO_WAIT_REQUEST, CPU_READY_N, SYS_ADDR_BIT0, SYS_ADDR_BIT0_OE, INVERTED_ADDR_BIT0;
	logic        LOW_BYTE_ENABLE_N, DMA_HOLD_REQUEST_IN, PROCESSOR_HOLD_ACK_IN, MASTER_DMA_ADDR_ENABLE_N;
	logic        DMAC_MEMW_N, PROCESSOR_HOLD_REQUEST, DMA_HOLD_ACK_OUT, DMA_READY_OUT, DMA_MEM_WRITE_CMD;
	logic        DMA_IO_READ_CMD_I, DMA_IO_READ_CMD_O, DMA_IO_READ_CMD_OE;
	logic        DMA_IO_WRITE_CMD_I, DMA_IO_WRITE_CMD_O, DMA_IO_WRITE_CMD_OE;
	logic        UPPER_RAM_ACCESS_ENABLE, SYSTEM_MEMORY_INDICATOR, COLOR_VIDEO_MEM_SELECT, BIOS_ROM_SEL_N;
	logic [1:0]  VIDEO_CHIP_SEL, cmd_sel;
	logic        BASE_RAM_ACCESS_N, REFRESH_ENABLE_IN, REFRESH_ACTIVE_OUT, REFRESH_COUNTER_PHASE, REFRESH_ADDR_BIT0;
	logic        SECOND_BYTE_DUMMY_ADDR, BYTE_SWAP_DIRECTION, BYTE_SWAP_ENABLE_N, DUMMY_ADDR_LATCH_STROBE;
	logic        go, busy, dmac_ior_n, dmac_iow_n, dmac_oe;
	int          n_mismatch = 0;
	int          num_checks = 0;

	// Pull-up when neither side drives
	assign DMA_IO_READ_CMD_I  = DMA_IO_READ_CMD_OE ? DMA_IO_READ_CMD_O : (dmac_oe ? dmac_ior_n : 1'b1);
	assign DMA_IO_WRITE_CMD_I = DMA_IO_WRITE_CMD_OE ? DMA_IO_WRITE_CMD_O : (dmac_oe ? dmac_iow_n : 1'b1);

	bcc_top uut (
		.MCLK, .SRST, .CE, .POWER_ON_RESET_N, .POWER_OFF_REQ, .PROCESSOR_RESET_OUT, .SYSTEM_RESET_OUT,
		.CPU_ADDR, .CPU_DATA_LO, .CPU_MEM_CYCLE, .CPU_READ, .CPU_BHE_N, .CPU_MEMW_N, .CPU_IOR_N, .CPU_IOW_N,
		.INT_ACK_N, .TARGET_8BIT, .ZERO_WAIT_REQUEST, .CPU_READY_N, .SYS_ADDR_BIT0, .SYS_ADDR_BIT0_OE,
		.INVERTED_ADDR_BIT0, .LOW_BYTE_ENABLE_N, .FIRST_BYTE, .DMA_HOLD_REQUEST_IN, .PROCESSOR_HOLD_ACK_IN,
		.MASTER_DMA_ADDR_ENABLE_N, .DMAC_MEMW_N, .PROCESSOR_HOLD_REQUEST, .DMA_HOLD_ACK_OUT, .DMA_READY_OUT,
		.DMA_MEM_WRITE_CMD, .DMA_IO_READ_CMD_I, .DMA_IO_READ_CMD_O, .DMA_IO_READ_CMD_OE, .DMA_IO_WRITE_CMD_I,
		.DMA_IO_WRITE_CMD_O, .DMA_IO_WRITE_CMD_OE, .UPPER_RAM_ACCESS_ENABLE, .SYSTEM_MEMORY_INDICATOR,
		.COLOR_VIDEO_MEM_SELECT, .VIDEO_CHIP_SEL, .BIOS_ROM_SEL_N, .BASE_RAM_ACCESS_N, .REFRESH_ENABLE_IN,
		.REFRESH_ACTIVE_OUT, .REFRESH_COUNTER_PHASE, .REFRESH_ADDR_BIT0, .SECOND_BYTE_DUMMY_ADDR,
		.BYTE_SWAP_DIRECTION, .BYTE_SWAP_ENABLE_N, .DUMMY_ADDR_LATCH_STROBE
	);

	bcc_partner dmac (
		.clk(MCLK), .go, .cmd_sel, .busy, .hold_req(PROCESSOR_HOLD_REQUEST), .hold_ack(DMA_HOLD_ACK_OUT),
		.dma_ready(DMA_READY_OUT), .hold_grant(PROCESSOR_HOLD_ACK_IN), .dma_hrq(DMA_HOLD_REQUEST_IN),
		.aen_n(MASTER_DMA_ADDR_ENABLE_N), .memw_n(DMAC_MEMW_N), .ior_n(dmac_ior_n), .iow_n(dmac_iow_n),
		.cmd_oe(dmac_oe)
	);

	// ----------
	// Shared tasks
	// ----------
	task automatic check(input string name, input logic [23:0] seen, input logic [23:0] exp);
		num_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("MISMATCH %s expected %0h seen %0h", name, exp, seen);
		end
	endtask

	// Sample once the edge has settled
	task automatic step(input int n);
		repeat (n) @(posedge MCLK);
		#1;
	endtask

	task automatic conclude();
		if (n_mismatch == 0 && num_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	// ----------
	// Scenarios
	// ----------
	task automatic t_reset();
		repeat (2) @(posedge MCLK);
		SRST <= 1'b0;
		step(1);
		check("proc_reset", PROCESSOR_RESET_OUT, 1'b1);
		check("dma_ready", DMA_READY_OUT, 1'b1);
		check("ref_phase", REFRESH_COUNTER_PHASE, 1'b1);
		check("first_byte", FIRST_BYTE, 8'h00);
		step(6);
		check("sys_reset_por", SYSTEM_RESET_OUT, 1'b1);
		check("proc_reset_por", PROCESSOR_RESET_OUT, 1'b1);
		@(posedge MCLK);
		POWER_ON_RESET_N <= 1'b1;
		step(6);
		check("sys_reset_run", SYSTEM_RESET_OUT, 1'b0);
		check("proc_reset_run", PROCESSOR_RESET_OUT, 1'b0);
		@(posedge MCLK);
		POWER_OFF_REQ <= 1'b1;
		step(4);
		check("proc_reset_off", PROCESSOR_RESET_OUT, 1'b1);
		check("sys_reset_off", SYSTEM_RESET_OUT, 1'b0);
		@(posedge MCLK);
		POWER_OFF_REQ <= 1'b0;
		step(4);
		check("proc_reset_clr", PROCESSOR_RESET_OUT, 1'b0);
	endtask

	task automatic t_cpu();
		@(posedge MCLK);
		CPU_ADDR <= 24'h000001;
		CPU_MEMW_N <= 1'b0;
		CPU_IOR_N <= 1'b0;
		CPU_IOW_N <= 1'b0;
		step(4);
		check("sa0", {SYS_ADDR_BIT0, SYS_ADDR_BIT0_OE}, 2'b11);
		check("inv_a0", {INVERTED_ADDR_BIT0, LOW_BYTE_ENABLE_N}, 2'b01);
		check("memw", DMA_MEM_WRITE_CMD, 1'b0);
		check("ior", {DMA_IO_READ_CMD_O, DMA_IO_READ_CMD_OE, DMA_IO_WRITE_CMD_O, DMA_IO_WRITE_CMD_OE}, 4'h5);
		@(posedge MCLK);
		INT_ACK_N <= 1'b0;
		CPU_MEMW_N <= 1'b1;
		CPU_IOR_N <= 1'b1;
		CPU_IOW_N <= 1'b1;
		step(4);
		check("sa0_inta", SYS_ADDR_BIT0, 1'b0);
		check("memw_idle", DMA_MEM_WRITE_CMD, 1'b1);
		check("io_idle", {DMA_IO_READ_CMD_O, DMA_IO_WRITE_CMD_O}, 2'b11);
		@(posedge MCLK);
		INT_ACK_N <= 1'b1;
		CPU_ADDR <= 24'h000000;
		CPU_MEM_CYCLE <= 1'b1;
		step(4);
		check("inv_a0_even", {INVERTED_ADDR_BIT0, LOW_BYTE_ENABLE_N}, 2'b10);
	endtask

	// Window edges: {video, rom_n, base_n}
	task automatic t_decode();
		logic [23:0] a [14] = '{24'h0B8000, 24'h0BBFFF, 24'h0B7FFF, 24'h0BC000, 24'h0E0000, 24'h0FFFFF,
			24'h0DFFFF, 24'hFE0000, 24'hFFFFFF, 24'hFDFFFF, 24'h09FFFF, 24'h0A0000, 24'h080000, 24'h000000};
		logic [2:0]  e [14] = '{3'h7, 3'h7, 3'h3, 3'h3, 3'h1, 3'h1, 3'h3, 3'h1, 3'h1, 3'h3, 3'h2, 3'h3, 3'h2, 3'h2};
		@(posedge MCLK);
		CPU_MEM_CYCLE <= 1'b1;
		for (int i = 0; i < 14; i++) begin
			@(posedge MCLK);
			CPU_ADDR <= a[i];
			step(4);
			check("video_sel", COLOR_VIDEO_MEM_SELECT, e[i][2]);
			check("rom_sel_n", BIOS_ROM_SEL_N, e[i][1]);
			check("base_ram_n", BASE_RAM_ACCESS_N, e[i][0]);
			check("vram_chip", VIDEO_CHIP_SEL, a[i][16:15]);
		end
		@(posedge MCLK);
		SYSTEM_MEMORY_INDICATOR <= 1'b0;
		step(4);
		check("base_ram_other", BASE_RAM_ACCESS_N, 1'b1);
		@(posedge MCLK);
		SYSTEM_MEMORY_INDICATOR <= 1'b1;
		CPU_MEM_CYCLE <= 1'b0;
		step(4);
	endtask

	task automatic t_ready();
		int n;
		for (int z = 0; z < 2; z++) begin
			@(posedge MCLK);
			CPU_ADDR <= 24'h000200;
			ZERO_WAIT_REQUEST <= z[0];
			step(4);
			check("ready_idle", CPU_READY_N, 1'b1);
			@(posedge MCLK);
			CPU_MEM_CYCLE <= 1'b1;
			n = 0;
			while (CPU_READY_N !== 1'b0 && n < 10) begin
				step(1);
				n++;
			end
			check("ready_edges", 24'(n), 24'(4 - z));
			step(2);
			check("ready_hold", CPU_READY_N, 1'b0);
			@(posedge MCLK);
			CPU_MEM_CYCLE <= 1'b0;
		end
		step(4);
	endtask

	task automatic t_conv();
		int n;
		for (int rd = 1; rd >= 0; rd--) begin
			@(posedge MCLK);
			TARGET_8BIT <= 1'b1;
			CPU_BHE_N <= 1'b0;
			CPU_ADDR <= 24'h000100;
			CPU_READ <= rd[0];
			CPU_DATA_LO <= rd[0] ? 8'hA5 : 8'h3C;
			step(4);
			@(posedge MCLK);
			CPU_MEM_CYCLE <= 1'b1;
			n = 0;
			while (DUMMY_ADDR_LATCH_STROBE !== 1'b1 && n < 10) begin
				step(1);
				n++;
			end
			check("strobe", DUMMY_ADDR_LATCH_STROBE, 1'b1);
			check("swap_en_early", BYTE_SWAP_ENABLE_N, 1'b1);
			step(1);
			check("strobe_pulse", DUMMY_ADDR_LATCH_STROBE, 1'b0);
			check("dummy_addr", SECOND_BYTE_DUMMY_ADDR, 1'b1);
			check("swap_en", BYTE_SWAP_ENABLE_N, 1'b0);
			check("swap_dir", BYTE_SWAP_DIRECTION, rd[0]);
			step(1);
			check("dummy_end", SECOND_BYTE_DUMMY_ADDR, 1'b0);
			check("swap_en_end", BYTE_SWAP_ENABLE_N, 1'b1);
			check("first_byte", FIRST_BYTE, 8'hA5);
			@(posedge MCLK);
			CPU_MEM_CYCLE <= 1'b0;
			TARGET_8BIT <= 1'b0;
			CPU_BHE_N <= 1'b1;
			step(4);
		end
	endtask

	task automatic t_refresh();
		int lows;
		logic [1:0] seen;
		@(posedge MCLK);
		REFRESH_ENABLE_IN <= 1'b1;
		step(6);
		lows = 0;
		seen = 2'b00;
		repeat (32) begin
			step(1);
			if (REFRESH_COUNTER_PHASE === 1'b0) begin
				lows++;
				check("ref_active", REFRESH_ACTIVE_OUT, 1'b1);
				seen = seen | (REFRESH_ADDR_BIT0 ? 2'b10 : 2'b01);
			end
		end
		check("ref_low_cycles", 24'(lows), 24'd16);
		check("ref_row_bits", seen, 2'b11);
		@(posedge MCLK);
		REFRESH_ENABLE_IN <= 1'b0;
	endtask

	task automatic t_dma(input logic [1:0] sel);
		int n;
		int lows;
		logic mem_lo;
		@(posedge MCLK);
		cmd_sel <= sel;
		go <= 1'b1;
		@(posedge MCLK);
		go <= 1'b0;
		n = 0;
		while (PROCESSOR_HOLD_REQUEST !== 1'b1 && n < 10) begin
			step(1);
			n++;
		end
		check("hold_req", PROCESSOR_HOLD_REQUEST, 1'b1);
		check("hold_ack_early", DMA_HOLD_ACK_OUT, 1'b0);
		lows = 0;
		mem_lo = 1'b0;
		while (busy === 1'b1 && n < 80) begin
			step(1);
			n++;
			lows += (DMA_READY_OUT === 1'b0);
			mem_lo |= (DMAC_MEMW_N === 1'b0 && DMA_MEM_WRITE_CMD === 1'b0);
			if (DMA_HOLD_ACK_OUT === 1'b1) begin
				check("ack_after_grant", PROCESSOR_HOLD_ACK_IN, 1'b1);
				check("oe_in_dma", {DMA_IO_READ_CMD_OE, DMA_IO_WRITE_CMD_OE, SYS_ADDR_BIT0_OE}, 3'h0);
			end
		end
		check("dma_wait_cycles", 24'(lows), 24'd1);
		check("dma_memw", mem_lo, sel == 2'd2);
		step(6);
		check("hold_release", {PROCESSOR_HOLD_REQUEST, DMA_HOLD_ACK_OUT}, 2'b00);
	endtask

	// ----------
	// Clock, watchdog and main sequence
	// ----------
	initial begin
		MCLK = 1'b0;
		forever #20 MCLK = ~MCLK;
	end

	// Run needs under a thousand cycles
	initial begin
		#100000;
		n_mismatch++;
		conclude();
	end

	initial begin
		SRST = 1'b1;
		CE = 1'b1;
		POWER_ON_RESET_N = 1'b0;
		POWER_OFF_REQ = 1'b0;
		CPU_ADDR = 24'h000000;
		CPU_DATA_LO = 8'h00;
		CPU_MEM_CYCLE = 1'b0;
		CPU_READ = 1'b1;
		CPU_BHE_N = 1'b1;
		CPU_MEMW_N = 1'b1;
		CPU_IOR_N = 1'b1;
		CPU_IOW_N = 1'b1;
		INT_ACK_N = 1'b1;
		TARGET_8BIT = 1'b0;
		ZERO_WAIT_REQUEST = 1'b0;
		UPPER_RAM_ACCESS_ENABLE = 1'b0;
		SYSTEM_MEMORY_INDICATOR = 1'b1;
		REFRESH_ENABLE_IN = 1'b0;
		go = 1'b0;
		cmd_sel = 2'd0;
		t_reset();
		t_cpu();
		t_decode();
		t_ready();
		t_conv();
		t_refresh();
		for (int s = 0; s < 3; s++) begin
			t_dma(s[1:0]);
		end
		conclude();
	end
endmodule // testbench
`default_nettype wire
